/* File: core/humidity_temp_result_output.sv */
// result delivery of the humidity/temperature sensor: serial link, pwm, analogue code
// assumes sclClk is the serial clock pin (stands still between frames), and that
// the converter answers each measStart with one adcValid pulse, code right aligned
module humidity_temp_result_output #(
  parameter int SOFT_RESET_CYCLES = humidity_result_pkg::SOFT_RESET_CYCLES,
  parameter int SAMPLE_INTERVAL_CYCLES = humidity_result_pkg::SAMPLE_INTERVAL_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclClk,
  input wire logic sdaIn,
  input wire logic [1:0] selPin,
  input wire logic adcValid,
  input wire logic [13:0] adcCode,
  output logic sdaOut,
  output logic sdaOeN,
  output logic measStart,
  output logic measHumid,
  output logic [3:0] measBits,
  output logic [15:0] analogueHumidityPin
);

  localparam int SW = $clog2(SOFT_RESET_CYCLES + 1);
  localparam int IW = $clog2(SAMPLE_INTERVAL_CYCLES + 1);
  localparam int PW = $clog2(humidity_result_pkg::PWM_PRESCALE + 1);

  // link domain registers, declared first for the synchronisers
  logic linkDrive;
  logic linkTog;
  logic readCfg;
  humidity_result_pkg::link_msg_s linkMsg;
  humidity_result_pkg::link_phase_e phase;
  humidity_result_pkg::link_phase_e pendPhase;
  logic [3:0] bitCnt;
  logic [6:0] shiftIn;
  logic ackOn;
  logic [1:0] byteIdx;

  // ---------------------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ---------------------------------------------------------------------------
  wire logic [5:0] syncIn = {selPin, sclClk, sdaIn, linkDrive, linkTog};
  logic [5:0] syncA;
  logic [5:0] syncB;
  logic [2:0] syncC;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      // idle levels: no false start edge, no stand-alone sample from a stale strap
      syncA <= humidity_result_pkg::SYNC_IDLE;
      syncB <= humidity_result_pkg::SYNC_IDLE;
      syncC <= humidity_result_pkg::SYNC_PREV_IDLE;
    end
    else
    begin
      syncA <= syncIn;
      syncB <= syncA;
      syncC <= {syncB[3], syncB[2], syncB[0]};
    end
  end

  wire humidity_result_pkg::mode_e mode = humidity_result_pkg::mode_e'(syncB[5:4]);
  wire logic sclS = syncB[3];
  wire logic sdaS = syncB[2];
  wire logic driveS = syncB[1];
  wire logic startSeen = sclS & syncC[2] & syncC[1] & !sdaS;
  wire logic stopSeen = sclS & syncC[2] & !syncC[1] & sdaS;
  wire logic msgEvent = syncB[0] ^ syncC[0];

  // ---------------------------------------------------------------------------
  // frame tracking; linkHold parks the link logic from start until scl falls
  // ---------------------------------------------------------------------------
  logic linkHold;
  logic frameActive;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      linkHold <= 1'h1;
      frameActive <= 1'h0;
    end
    else
    begin
      linkHold <= startSeen | (linkHold & sclS);
      frameActive <= startSeen | (frameActive & !stopSeen);
    end
  end

  // ---------------------------------------------------------------------------
  // configuration, soft reset and measurement control
  // ---------------------------------------------------------------------------
  logic [7:0] cfg;
  logic [SW-1:0] softCnt;
  logic [IW-1:0] sampleCnt;
  logic measPending;
  logic pendSerial;
  logic pendHumid;
  logic [3:0] pendBits;
  logic [15:0] resultWord;
  logic resultValid;
  logic [7:0] resultCrc;
  humidity_result_pkg::link_view_s view;

  wire logic softBusy = softCnt != '0;
  wire logic softEvt = msgEvent && linkMsg.kind == humidity_result_pkg::MSG_SOFT_RESET;
  wire logic writeEvt = msgEvent && linkMsg.kind == humidity_result_pkg::MSG_WRITE_CFG;
  wire logic measEvt = msgEvent && (linkMsg.kind == humidity_result_pkg::MSG_MEAS_T ||
                                    linkMsg.kind == humidity_result_pkg::MSG_MEAS_H);
  wire logic reloadNow = measEvt && !cfg[humidity_result_pkg::CFG_RELOAD_OFF_BIT];
  wire logic [7:0] cfgUsed = reloadNow ? humidity_result_pkg::CFG_DEFAULT : cfg;
  wire logic [1:0] resCode = {cfgUsed[humidity_result_pkg::CFG_RES_HI_BIT],
                              cfgUsed[humidity_result_pkg::CFG_RES_LO_BIT]};
  wire logic serialHumid = linkMsg.kind == humidity_result_pkg::MSG_MEAS_H;
  wire logic startSerial = measEvt && mode == humidity_result_pkg::MODE_SERIAL && !softBusy && !measPending;
  wire logic standaloneTick = sampleCnt == '0 && mode != humidity_result_pkg::MODE_SERIAL &&
                              !softBusy && !measPending;
  wire logic standaloneHumid = mode == humidity_result_pkg::MODE_ANALOGUE ? 1'h1 : sclS;
  wire logic [3:0] next_measBits = startSerial
    ? (serialHumid ? humidity_result_pkg::RES_H_BITS[resCode] : humidity_result_pkg::RES_T_BITS[resCode])
    : (standaloneHumid ? humidity_result_pkg::STANDALONE_H_BITS : humidity_result_pkg::STANDALONE_T_BITS);
  wire logic [7:0] next_cfg = (cfg & ~humidity_result_pkg::CFG_WRITE_MASK) |
                              (linkMsg.data & humidity_result_pkg::CFG_WRITE_MASK);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cfg <= humidity_result_pkg::CFG_DEFAULT;
    else if (softEvt || reloadNow)
      cfg <= humidity_result_pkg::CFG_DEFAULT;
    else if (writeEvt)
      cfg <= next_cfg;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      softCnt <= '0;
    else if (softEvt)
      softCnt <= SW'(SOFT_RESET_CYCLES);
    else if (softBusy)
      softCnt <= softCnt - 1'h1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      sampleCnt <= '0;
    else if (softEvt)
      sampleCnt <= '0;
    else if (standaloneTick || sampleCnt != '0)
      sampleCnt <= sampleCnt == '0 ? IW'(SAMPLE_INTERVAL_CYCLES - 1) : sampleCnt - 1'h1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      measStart <= 1'h0;
      measHumid <= 1'h0;
      measBits <= 4'h0;
      measPending <= 1'h0;
      pendSerial <= 1'h0;
    end
    else
    begin
      measStart <= startSerial | standaloneTick;
      if (startSerial || standaloneTick)
      begin
        measHumid <= startSerial ? serialHumid : standaloneHumid;
        measBits <= next_measBits;
        pendSerial <= startSerial;
      end
      measPending <= !softEvt && (startSerial || standaloneTick || (measPending && !adcValid));
    end
  end

  assign pendHumid = measHumid;
  assign pendBits = measBits;

  // ---------------------------------------------------------------------------
  // result word: left aligned, status in the two lowest bits
  // ---------------------------------------------------------------------------
  wire logic [4:0] shiftAmt = 5'(5'h10 - {1'h0, pendBits});
  wire logic [15:0] alignedCode = 16'(adcCode) << shiftAmt;
  wire logic [15:0] next_resultWord = {alignedCode[15:2], pendHumid, 1'h0};
  wire logic resultDone = adcValid && measPending;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      resultWord <= '0;
      resultValid <= 1'h0;
      analogueHumidityPin <= '0;
    end
    else
    begin
      if (resultDone && pendSerial)
        resultWord <= next_resultWord;
      if (resultDone && !pendSerial && mode == humidity_result_pkg::MODE_ANALOGUE)
        analogueHumidityPin <= next_resultWord;
      resultValid <= !softEvt && !startSerial && (resultValid || (resultDone && pendSerial));
    end
  end

  crc8_checksum #(.WIDTH(16)) u_crc (
    .data(resultWord),
    .crc(resultCrc)
  );

  // only refreshed while the bus is idle, so the link sees stable words
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      view <= '{cfg: humidity_result_pkg::CFG_DEFAULT, default: '0};
    else if (!frameActive)
      view <= '{cfg: cfg, result: {resultWord, resultCrc}, resultValid: resultValid, busy: softBusy};
  end

  // ---------------------------------------------------------------------------
  // pwm: phase counter against the latched word gives a pure duty ratio
  // ---------------------------------------------------------------------------
  logic [PW-1:0] pwmPre;
  logic [15:0] pwmPhase;
  logic [15:0] pwmLatest;
  logic [15:0] pwmWord;
  wire logic pwmStep = pwmPre == PW'(humidity_result_pkg::PWM_PRESCALE - 1);
  wire logic pwmWrap = pwmStep && pwmPhase == 16'hffff;
  wire logic pwmHigh = pwmPhase < pwmWord;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pwmPre <= '0;
      pwmPhase <= '0;
      pwmLatest <= '0;
      pwmWord <= '0;
    end
    else
    begin
      pwmPre <= pwmStep ? '0 : pwmPre + 1'h1;
      pwmPhase <= pwmStep ? pwmPhase + 1'h1 : pwmPhase;
      if (resultDone && !pendSerial)
        pwmLatest <= {next_resultWord[15:2], 2'h0};
      // new value only at a period boundary so no period is torn
      if (pwmWrap)
        pwmWord <= pwmLatest;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sdaOut <= 1'h0;
      sdaOeN <= 1'h1;
    end
    else
    begin
      sdaOut <= 1'h0;
      sdaOeN <= mode == humidity_result_pkg::MODE_SERIAL ? !driveS :
                mode == humidity_result_pkg::MODE_PWM ? pwmHigh : 1'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // serial link, clocked by the bus clock
  // ---------------------------------------------------------------------------
  wire logic [7:0] rxByte = {shiftIn, sdaIn};
  wire logic byteEnd = bitCnt == 4'h7;
  wire logic addrHit = rxByte[7:1] == humidity_result_pkg::DEVICE_ADDR && !view.busy &&
                       (!rxByte[0] || readCfg || view.resultValid);
  wire logic isMeasCmd = rxByte == humidity_result_pkg::CMD_MEAS_T_HOLD || rxByte == humidity_result_pkg::CMD_MEAS_H_HOLD ||
                         rxByte == humidity_result_pkg::CMD_MEAS_T_POLL || rxByte == humidity_result_pkg::CMD_MEAS_H_POLL;
  wire logic knownCmd = isMeasCmd || rxByte == humidity_result_pkg::CMD_WRITE_CFG ||
                        rxByte == humidity_result_pkg::CMD_READ_CFG || rxByte == humidity_result_pkg::CMD_SOFT_RESET;
  wire logic cmdDone = byteEnd && phase == humidity_result_pkg::PH_CMD;
  wire logic dataDone = byteEnd && phase == humidity_result_pkg::PH_WDATA;
  wire logic sendMsg = (cmdDone && (isMeasCmd || rxByte == humidity_result_pkg::CMD_SOFT_RESET)) || dataDone;
  wire logic [1:0] lastIdx = readCfg ? 2'h0 : 2'h2;
  wire logic [7:0] txByte = readCfg ? view.cfg : view.result[5'(8 * (2 - byteIdx)) +: 8];
  wire logic txBit = txByte[3'(4'h7 - bitCnt)];

  always_ff @(posedge sclClk or posedge linkHold)
  begin
    if (linkHold)
    begin
      bitCnt <= 4'h0;
      shiftIn <= '0;
      phase <= humidity_result_pkg::PH_ADDR;
      pendPhase <= humidity_result_pkg::PH_IGNORE;
      ackOn <= 1'h0;
      byteIdx <= 2'h0;
    end
    else
    begin
      bitCnt <= bitCnt == 4'h8 ? 4'h0 : bitCnt + 1'h1;
      shiftIn <= {shiftIn[5:0], sdaIn};
      if (byteEnd)
      begin
        ackOn <= phase == humidity_result_pkg::PH_ADDR ? addrHit :
                 phase == humidity_result_pkg::PH_CMD ? knownCmd :
                 phase == humidity_result_pkg::PH_WDATA;
        pendPhase <= phase == humidity_result_pkg::PH_ADDR && addrHit
                     ? (rxByte[0] ? humidity_result_pkg::PH_READ : humidity_result_pkg::PH_CMD)
                     : (cmdDone && rxByte == humidity_result_pkg::CMD_WRITE_CFG
                        ? humidity_result_pkg::PH_WDATA : humidity_result_pkg::PH_IGNORE);
      end
      if (bitCnt == 4'h8 && phase != humidity_result_pkg::PH_READ)
        phase <= pendPhase;
      else if (bitCnt == 4'h8 && (sdaIn || byteIdx == lastIdx))
        phase <= humidity_result_pkg::PH_IGNORE;
      else if (bitCnt == 4'h8)
        byteIdx <= byteIdx + 1'h1;
    end
  end

  always_ff @(negedge sclClk or posedge linkHold)
  begin
    if (linkHold)
      linkDrive <= 1'h0;
    else
      linkDrive <= bitCnt == 4'h8 ? ackOn : (phase == humidity_result_pkg::PH_READ && !txBit);
  end

  // survives the per-frame hold: a register read spans two frames
  always_ff @(posedge sclClk or posedge reset)
  begin
    if (reset)
    begin
      linkTog <= 1'h0;
      linkMsg <= '{kind: humidity_result_pkg::MSG_MEAS_T, data: 8'h00};
      readCfg <= 1'h0;
    end
    else if (!linkHold)
    begin
      if (sendMsg)
      begin
        linkTog <= !linkTog;
        linkMsg.data <= rxByte;
        linkMsg.kind <= dataDone ? humidity_result_pkg::MSG_WRITE_CFG :
                        rxByte == humidity_result_pkg::CMD_SOFT_RESET ? humidity_result_pkg::MSG_SOFT_RESET :
                        rxByte[2] ? humidity_result_pkg::MSG_MEAS_H : humidity_result_pkg::MSG_MEAS_T;
      end
      if (cmdDone && knownCmd)
        readCfg <= rxByte == humidity_result_pkg::CMD_READ_CFG;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  property p_reserved;
    @(posedge clk) disable iff (reset) cfg[6:2] == 5'h0e;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved configuration bits changed");

  property p_soft_default;
    @(posedge clk) disable iff (reset) softEvt |=> cfg == humidity_result_pkg::CFG_DEFAULT && softBusy;
  endproperty
  a_soft_default: assert property (p_soft_default) else $error("soft reset left configuration");

  property p_soft_quiet;
    @(posedge clk) disable iff (reset) softBusy |-> !startSerial && !standaloneTick;
  endproperty
  a_soft_quiet: assert property (p_soft_quiet) else $error("measurement during soft reset");

  property p_write_fields;
    @(posedge clk) disable iff (reset) writeEvt && !softEvt |=> cfg == ($past(cfg) & 8'h7c | $past(linkMsg.data) & 8'h83);
  endproperty
  a_write_fields: assert property (p_write_fields) else $error("configuration write wrong");

  property p_reload;
    @(posedge clk) disable iff (reset) reloadNow && !writeEvt |=> cfg == humidity_result_pkg::CFG_DEFAULT;
  endproperty
  a_reload: assert property (p_reload) else $error("factory reload missed");

  property p_status_type;
    @(posedge clk) disable iff (reset) resultDone && pendSerial |=> resultWord[1:0] == {$past(measHumid), 1'h0};
  endproperty
  a_status_type: assert property (p_status_type) else $error("status bits wrong");

  property p_align8;
    @(posedge clk) disable iff (reset)
      resultDone && pendSerial && pendBits == 4'h8 |=> resultWord[15:8] == $past(adcCode[7:0]) && resultWord[7:2] == 6'h00;
  endproperty
  a_align8: assert property (p_align8) else $error("result not left aligned");

  property p_crc_third;
    @(posedge clk) disable iff (reset) !frameActive ##1 1 |-> view.result[7:0] == $past(resultCrc);
  endproperty
  a_crc_third: assert property (p_crc_third) else $error("checksum byte stale");

  property p_analogue_sample;
    @(posedge clk) disable iff (reset)
      standaloneTick && mode == humidity_result_pkg::MODE_ANALOGUE |=> measStart && measHumid && measBits == 4'ha;
  endproperty
  a_analogue_sample: assert property (p_analogue_sample) else $error("analogue sample wrong");

  property p_pwm_type;
    @(posedge clk) disable iff (reset)
      standaloneTick && mode == humidity_result_pkg::MODE_PWM |=> measHumid == $past(sclS) && measBits == (measHumid ? 4'ha : 4'hc);
  endproperty
  a_pwm_type: assert property (p_pwm_type) else $error("pwm sample type wrong");

  property p_addr_ack;
    @(posedge sclClk) disable iff (linkHold)
      byteEnd && phase == humidity_result_pkg::PH_ADDR && rxByte[7:1] != humidity_result_pkg::DEVICE_ADDR |=> !ackOn;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("acknowledged a foreign address");

  c_soft_reset: cover property (@(posedge clk) disable iff (reset) softEvt);
  c_cfg_write: cover property (@(posedge clk) disable iff (reset) writeEvt);
  c_serial_result: cover property (@(posedge clk) disable iff (reset) resultDone && pendSerial);
  c_pwm_wrap: cover property (@(posedge clk) disable iff (reset) pwmWrap && pwmWord != 16'h0000);

endmodule

/* File: core/humidity_result_pkg.sv */
// constants, types and helpers shared by the humidity/temperature result logic
// assumes a 100 MHz core clock and an open-drain serial bus clocked by the host
// ----------------------------------------------------------------------------
// Summary of operation
// - soft reset command restores every configuration bit to its default value
// - soft reset completes within 15 ms; no command answered meanwhile
// - reserved bits 6..3 default 0111 and bit 2 default 0 never change
// - bits 7 and 0 select resolution: 00 12/14, 01 8/12, 10 10/13, 11 11/11
// - bit 1 low reloads factory defaults on every measurement command
// - eight-bit checksum with polynomial x^8+x^5+x^4+1 follows the result
// - result is two bytes, high byte first, each byte msb first, left aligned
// - receiver of each byte drives its acknowledge bit
// - humidity word fills the full 16-bit range at every resolution
// - temperature word fills the full 16-bit range at every resolution
// - select pins 00 give analogue humidity, two samples per second, 10 bits
// - select pins 01 give pwm on data line; clock level picks humidity
// - pwm base frequency about 120 Hz, period about 8.3 ms; the prescaler of 12 gives 7.86 ms here, about 127 Hz
// - pwm mode samples twice per second, humidity 10 bits, temperature 12
// - pwm value is high time over period; receiver evaluates the ratio
// - status bit 1 marks humidity as 1, temperature as 0; bit 0 unused
// - device answers serial address 1000000; direction bit 1 reads
// ----------------------------------------------------------------------------
package humidity_result_pkg;

  typedef enum logic [1:0] {MODE_ANALOGUE, MODE_PWM, MODE_PDM, MODE_SERIAL} mode_e;
  typedef enum logic [1:0] {MSG_MEAS_T, MSG_MEAS_H, MSG_WRITE_CFG, MSG_SOFT_RESET} msg_kind_e;
  typedef enum logic [2:0] {PH_ADDR, PH_CMD, PH_WDATA, PH_READ, PH_IGNORE} link_phase_e;

  typedef struct packed {
    msg_kind_e kind;
    logic [7:0] data;
  } link_msg_s;

  // core state as seen from the link, only refreshed between frames
  typedef struct packed {
    logic [7:0] cfg;
    logic [23:0] result;
    logic resultValid;
    logic busy;
  } link_view_s;

  localparam logic [6:0] DEVICE_ADDR = 7'h40;
  localparam logic [7:0] CMD_MEAS_T_HOLD = 8'he3;
  localparam logic [7:0] CMD_MEAS_H_HOLD = 8'he5;
  localparam logic [7:0] CMD_MEAS_T_POLL = 8'hf3;
  localparam logic [7:0] CMD_MEAS_H_POLL = 8'hf5;
  localparam logic [7:0] CMD_WRITE_CFG = 8'he6;
  localparam logic [7:0] CMD_READ_CFG = 8'he7;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hfe;

  localparam logic [7:0] CFG_DEFAULT = 8'h3a;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h83;
  localparam int CFG_RES_HI_BIT = 7;
  localparam int CFG_RES_LO_BIT = 0;
  localparam int CFG_RELOAD_OFF_BIT = 1;
  localparam int STATUS_TYPE_BIT = 1;

  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // synchroniser contents after reset: serial straps, bus lines released high
  localparam logic [5:0] SYNC_IDLE = 6'h3c;
  localparam logic [2:0] SYNC_PREV_IDLE = 3'h6;

  // result bits per resolution code, indexed by {bit7,bit0}
  localparam logic [3:0] RES_H_BITS [4] = '{4'hc, 4'h8, 4'ha, 4'hb};
  localparam logic [3:0] RES_T_BITS [4] = '{4'he, 4'hc, 4'hd, 4'hb};
  localparam logic [3:0] STANDALONE_H_BITS = 4'ha;
  localparam logic [3:0] STANDALONE_T_BITS = 4'hc;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFT_RESET_MS = 15;
  localparam int SOFT_RESET_CYCLES = SOFT_RESET_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SAMPLE_INTERVAL_MS = 500;
  localparam int SAMPLE_INTERVAL_CYCLES = SAMPLE_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PWM_PERIOD_US = 8300;
  localparam int PWM_STEPS = 65536;
  localparam int PWM_PRESCALE = PWM_PERIOD_US * 1000 / CLK_PERIOD_NS / PWM_STEPS;

endpackage

/* File: core/crc8_checksum.sv */
// bitwise checksum over a data word, msb first
// assumes the caller holds the data stable; purely combinational
module crc8_checksum #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] data,
  output logic [7:0] crc
);

  logic [7:0] stage [WIDTH+1];

  assign stage[0] = humidity_result_pkg::CRC_INIT;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      wire logic feedback = stage[i][7] ^ data[WIDTH-1-i];
      assign stage[i+1] = feedback ? ({stage[i][6:0], 1'h0} ^ humidity_result_pkg::CRC_POLY)
                                   : {stage[i][6:0], 1'h0};
    end
  endgenerate

  assign crc = stage[WIDTH];

endmodule

/* File: sim/serial_host_model.sv */
// host side of the serial bus: makes the bus clock only inside frames
// assumes the bench resolves the data line with a pull-up
module serial_host_model (
  output logic scl,
  output logic pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // data moves only while the clock is low; sampled at the rise
  task automatic bit_io(input logic b, output logic r);
    #20 pull = !b;
    #60 scl = 1'b1;
    r = sda;
    #80 scl = 1'b0;
  endtask
  // ackIn high releases the line so the receiving device acknowledges
  task automatic xfer(input logic [7:0] w, input logic ackIn, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(ackIn, ack);
  endtask
  task automatic start();
    #20 pull = 1'b0;
    #40 scl = 1'b1;
    #40 pull = 1'b1;
    #80 scl = 1'b0;
  endtask
  // clock then stands still until the next frame
  task automatic stop();
    #20 pull = 1'b1;
    #60 scl = 1'b1;
    #80 pull = 1'b0;
    #400;
  endtask
endmodule

/* File: sim/humidity_temp_result_output_bench.sv */
// bench for the result output block: configuration, results, soft reset
// assumes serial straps except in the stand-alone tests; the bench plays the converter
module humidity_temp_result_output_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SR = 2000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic adcValid = 1'b0;
  logic [13:0] adcCode = 14'h0;
  logic [1:0] selPin = 2'b11;
  logic scl, pull, sdaOut, sdaOeN, measStart, measHumid, seenHumid;
  logic [3:0] measBits, seenBits;
  logic [15:0] analogueHumidityPin;
  wire logic sda = pull ? 1'b0 : (sdaOeN ? 1'b1 : sdaOut);
  int n_mismatch = 0;
  int comparisons = 0;
  int nStart = 0;
  initial forever #5 clk = !clk;
  serial_host_model host (.scl(scl), .pull(pull), .sda(sda));
  humidity_temp_result_output #(.SOFT_RESET_CYCLES(SR), .SAMPLE_INTERVAL_CYCLES(500)) uut (.clk(clk),
    .reset(reset), .sclClk(scl), .sdaIn(sda), .selPin(selPin), .adcValid(adcValid), .adcCode(adcCode),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .measStart(measStart), .measHumid(measHumid), .measBits(measBits),
    .analogueHumidityPin(analogueHumidityPin));
  always @(posedge clk)
    if (measStart)
    begin
      nStart <= nStart + 1;
      seenHumid <= measHumid;
      seenBits <= measBits;
    end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_start(input int k);
    for (int i = 0; i < 600 && nStart == k; i++) @(posedge clk);
    if (nStart == k)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic convert(input logic [13:0] code);
    #1 adcValid = 1'b1;
    adcCode = code;
    @(posedge clk);
    #1 adcValid = 1'b0;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic cmd(input logic [7:0] c, input logic [7:0] data, input logic hasData);
    logic [7:0] r;
    logic a, b, e;
    e = 1'b0;
    host.start();
    host.xfer(8'h80, 1'b1, r, a);
    host.xfer(c, 1'b1, r, b);
    if (hasData) host.xfer(data, 1'b1, r, e);
    host.stop();
    check({a, b, e}, 3'b000);
  endtask
  task automatic read_cfg(input logic [7:0] exp);
    logic [7:0] r, v;
    logic a, b, c, d;
    host.start();
    host.xfer(8'h80, 1'b1, r, a);
    host.xfer(8'he7, 1'b1, r, b);
    host.start();
    host.xfer(8'h81, 1'b1, r, c);
    host.xfer(8'hff, 1'b1, v, d);
    host.stop();
    check({a, b, c, v}, {3'b000, exp});
    $display("config read done");
  endtask
  task automatic meas(input logic [7:0] c, input logic hum, input logic [3:0] bits, input logic [13:0] code);
    logic [7:0] r, b1, b2, b3;
    logic a;
    logic [15:0] w;
    int k;
    k = nStart;
    cmd(c, 8'h00, 1'b0);
    wait_start(k);
    check({seenHumid, seenBits}, {hum, bits});
    convert(code);
    // status bits travel in the two lowest places of the word
    w = 16'({2'b00, code} << (16 - bits));
    w[1:0] = {hum, 1'b0};
    host.start();
    host.xfer(8'h81, 1'b1, r, a);
    host.xfer(8'hff, 1'b0, b1, r[0]);
    host.xfer(8'hff, 1'b0, b2, r[0]);
    host.xfer(8'hff, 1'b1, b3, r[0]);
    host.stop();
    check({a, b1, b2, b3}, {1'b0, w, crc8(w)});
    check({b1, b2} & 16'hfffc, 16'({2'h0, code} << (16 - bits)));
    $display("measurement done");
  endtask
  task automatic standalone(input logic [1:0] sel, input logic [13:0] code, input logic [15:0] pin);
    int k;
    k = nStart;
    selPin = sel;
    wait_start(k);
    check({seenHumid, seenBits}, {1'h1, 4'ha});
    convert(code);
    check(analogueHumidityPin, pin);
    $display("standalone done");
  endtask
  task automatic soft_reset();
    logic [7:0] r;
    logic a;
    cmd(8'hfe, 8'h00, 1'b0);
    host.start();
    host.xfer(8'h80, 1'b1, r, a);
    host.stop();
    check(a, 1'b1);
    repeat (SR) @(posedge clk);
    #1 host.start();
    host.xfer(8'h82, 1'b1, r, a);
    host.stop();
    check(a, 1'b1);
    read_cfg(8'h3a);
    $display("soft reset done");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    read_cfg(8'h3a);
    meas(8'he3, 1'b0, 4'he, 14'h2abc);
    cmd(8'he6, 8'hff, 1'b1);
    read_cfg(8'hbb);
    meas(8'hf5, 1'b1, 4'hb, 14'h05a3);
    cmd(8'he6, 8'h81, 1'b1);
    meas(8'he5, 1'b1, 4'hc, 14'h0c35);
    read_cfg(8'h3a);
    cmd(8'he6, 8'h3b, 1'b1);
    meas(8'hf5, 1'b1, 4'h8, 14'h00c7);
    cmd(8'he6, 8'hbb, 1'b1);
    soft_reset();
    standalone(2'h0, 14'h02d9, 16'hb642);
    standalone(2'h1, 14'h01f4, 16'hb642);
    selPin = 2'h3;
    report_and_stop();
  end
endmodule
